/* File: hw/dcs_regs.sv */
// Disk command/status word bank with DMA feed to the formatter FIFO.
// Assumes host register port, host memory read port and formatter
// command/data ports all synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// data FIFO
module dcs_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } fifo_t;
    fifo_t q;
    fifo_t d;
    logic  push;
    logic  pop;

    assign in_ready  = (q.cnt != (AW+1)'(D));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + AW'(1);
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : dcs_fifo

// -----------------------------------------------------------------
// command / status word bank
// -----------------------------------------------------------------
module dcs_regs #(
    parameter int ST_CYCLES = 64,
    parameter int FIFO_D    = 16
) (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              IORST,
    input  wire logic              PWR_WARN,
    input  wire dcs_pkg::reg_req_t REG,
    output logic [15:0]            REG_RDATA,
    output dcs_pkg::mem_req_t      MEM_OUT,
    input  wire dcs_pkg::mem_rsp_t MEM_IN,
    output dcs_pkg::fmt_cmd_t      FMT_CMD,
    input  wire dcs_pkg::fmt_rsp_t FMT_RSP,
    output logic [15:0]            FMT_DATA,
    output logic                   FMT_DVALID,
    input  wire logic              FMT_DREADY,
    input  wire dcs_pkg::st_res_t  ST_RES,
    input  wire logic [3:0]        ATTN,
    output logic                   CMD_IRQ,
    output logic                   ATTN_IRQ
);
    import dcs_pkg::*;

    typedef struct packed {
        state_t      state;
        logic [3:0]  amask;
        logic        offl;
        logic [15:0] cmdw;
        logic [15:0] sterr;
        logic [15:0] maint;
        logic [15:0] count;
        logic [15:0] adlo;
        logic [15:0] unit;
        logic [15:0] stat;
        logic        st_fail;
        logic        loop;
        logic        ctl_cmd;
        logic        stop;
        logic [15:0] ctr;
        logic [15:0] rdata;
        logic        cirq;
        logic        airq;
        mem_req_t    mem;
        fmt_cmd_t    fcmd;
        logic        push_v;
        logic [15:0] push_d;
    } regs_t;

    regs_t       q;
    regs_t       d;
    logic        in_ready;
    logic        busy;
    logic        maint_sel;
    logic        ctl_maint;
    logic        onehot;
    logic        wr_type;
    logic        bus_to;
    logic        st_end;
    logic [15:0] rv;
    logic [19:0] baddr;
    logic [19:0] next_a;

    dcs_fifo #(.W(16), .D(FIFO_D)) u_fifo (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_valid  (q.push_v),
        .in_ready  (in_ready),
        .in_data   (q.push_d),
        .out_valid (FMT_DVALID),
        .out_ready (FMT_DREADY),
        .out_data  (FMT_DATA)
    );

    assign REG_RDATA = q.rdata;
    assign MEM_OUT   = q.mem;
    assign FMT_CMD   = q.fcmd;
    assign CMD_IRQ   = q.cirq;
    assign ATTN_IRQ  = q.airq;

    always_comb begin
        busy = !q.stat[B_IDLE];
        // extended msb plus code 111 opens the maintenance field
        maint_sel = q.cmdw[B_MSB] && (q.cmdw[10:8] == CODE_MAINT);
        ctl_maint = maint_sel && q.maint[B_CTRL];
        onehot = (q.unit[11:8] == 4'h8) || (q.unit[11:8] == 4'h4) ||
                 (q.unit[11:8] == 4'h2) || (q.unit[11:8] == 4'h1);
        // odd codes other than the maintenance code carry data from host memory to the drive
        wr_type = q.cmdw[8] && !maint_sel;
        // low word gives bits 14:1; its top bit is not address
        baddr = {q.unit[4:0], q.adlo[14:1], 1'b0};
        next_a = baddr + 20'(ADDR_STEP);
        bus_to = (q.ctr == 16'(BUS_TO_CYC - 1));
        st_end = (q.ctr == 16'(ST_CYCLES - 1));
        rv = '0;
        case (REG.sel)
            IDX_ATTN:  rv = {1'b0, q.offl, 6'h00, ATTN, q.amask};
            IDX_CMD:   rv = q.cmdw;
            IDX_STERR: rv = q.sterr;
            IDX_MAINT: rv = q.maint;
            IDX_COUNT: rv = q.count;
            IDX_ADLO:  rv = q.adlo;
            IDX_UNIT:  rv = q.unit;
            IDX_STAT:  rv = q.stat;
            default:   rv = '0;
        endcase
        if (busy) begin
            rv[B_MSB] = 1'b0;
        end

        d = q;
        d.fcmd.valid = 1'b0;
        if (REG.rd) begin
            d.rdata = rv;
        end
        if (q.push_v && in_ready) begin
            d.push_v = 1'b0;
        end
        // writes only land while idle; busy writes are dropped
        if (REG.wr && !busy) begin
            case (REG.sel)
                IDX_ATTN:  d.amask = REG.wdata[3:0];
                IDX_CMD:   d.cmdw = REG.wdata;
                IDX_MAINT: d.maint = REG.wdata;
                IDX_COUNT: d.count = REG.wdata;
                IDX_ADLO:  d.adlo = REG.wdata;
                IDX_UNIT:  d.unit = REG.wdata;
                IDX_STAT: begin
                    d.stat[B_CMP] = REG.wdata[B_CMP];
                    d.stat[B_ERR] = REG.wdata[B_ERR];
                    d.stat[B_IE] = REG.wdata[B_IE];
                    d.stat[B_IDLE] = REG.wdata[B_IDLE];
                end
                default: d.amask = q.amask;
            endcase
        end

        case (q.state)
            S_TEST: begin
                d.ctr = q.ctr + 16'h0001;
                if (st_end) begin
                    d.ctr = '0;
                    d.st_fail = ST_RES.fail;
                    if (ST_RES.fail) begin
                        d.sterr = {ST_RES.code, ST_RES.num};
                        d.stat[7:0] = ST_FAIL_BYTE;
                        d.stat[B_ERR] = 1'b1;
                    end
                    if (q.loop) begin
                        d.state = S_TEST;
                    end else if (busy) begin
                        d.state = S_END;
                    end else begin
                        d.state = S_IDLE;
                    end
                end
            end
            S_IDLE: begin
                if (busy) begin
                    d.ctr = '0;
                    d.stop = 1'b0;
                    d.ctl_cmd = ctl_maint;
                    d.stat[B_CMP] = 1'b0;
                    d.stat[B_ERR] = 1'b0;
                    if (!q.st_fail) begin
                        d.stat[7:0] = '0;
                    end
                    if (ctl_maint) begin
                        if (q.maint[13:8] <= MT_LAST_TEST) begin
                            d.loop = q.maint[B_LOOP];
                            d.state = S_TEST;
                        end else if (q.maint[13:8] == MT_WR_PMEM) begin
                            d.state = S_DMA;
                        end else begin
                            d.state = S_END;
                        end
                    end else if (!onehot) begin
                        d.stat[B_UE] = 1'b1;
                        d.stat[B_ERR] = 1'b1;
                        d.offl = 1'b1;
                        d.state = S_END;
                    end else if (q.st_fail) begin
                        // drive work is inhibited until a test passes
                        d.stat[B_ERR] = 1'b1;
                        d.state = S_END;
                    end else begin
                        d.offl = 1'b0;
                        d.state = S_FCMD;
                    end
                end
            end
            S_FCMD: begin
                d.fcmd.valid = 1'b1;
                d.fcmd.code = {q.cmdw[15:14], q.cmdw[10:8]};
                d.fcmd.unit = q.unit[11:8];
                d.fcmd.count = q.count;
                d.fcmd.maint = q.maint[15:8];
                d.state = wr_type ? S_DMA : S_FWAIT;
            end
            S_DMA: begin
                if (q.count == '0) begin
                    if (!q.push_v) begin
                        d.state = q.ctl_cmd ? S_END : S_FWAIT;
                    end
                end else if (!q.push_v) begin
                    if (q.stop) begin
                        // keep the formatter fed with filler bytes
                        d.push_v = 1'b1;
                        d.push_d = '0;
                        d.count = (q.count > ADDR_STEP) ?
                                  q.count - ADDR_STEP : '0;
                    end else if (!q.mem.req) begin
                        d.mem.req = 1'b1;
                        d.mem.addr = baddr;
                        d.ctr = '0;
                    end else if (MEM_IN.ack) begin
                        d.mem.req = 1'b0;
                        d.push_v = 1'b1;
                        d.push_d = MEM_IN.rdata;
                        d.count = (q.count > ADDR_STEP) ?
                                  q.count - ADDR_STEP : '0;
                        d.adlo = {q.adlo[B_MSB], next_a[14:1],
                                  q.adlo[B_ADLSB]};
                        d.unit[4:0] = next_a[19:15];
                    end else if (MEM_IN.err) begin
                        // address already stepped: error address + 2
                        d.mem.req = 1'b0;
                        d.stop = 1'b1;
                        d.stat[B_ME] = 1'b1;
                        d.stat[B_ERR] = 1'b1;
                        d.adlo = {q.adlo[B_MSB], next_a[14:1],
                                  q.adlo[B_ADLSB]};
                        d.unit[4:0] = next_a[19:15];
                    end else if (bus_to) begin
                        d.mem.req = 1'b0;
                        d.stop = 1'b1;
                        d.stat[B_TO] = 1'b1;
                        d.stat[B_ERR] = 1'b1;
                    end else begin
                        d.ctr = q.ctr + 16'h0001;
                    end
                end
            end
            S_FWAIT: begin
                if (FMT_RSP.done) begin
                    d.count = FMT_RSP.remain;
                    if (FMT_RSP.bus_err) begin
                        d.stat[B_CTO] = 1'b1;
                        d.stat[B_ERR] = 1'b1;
                    end
                    if (FMT_RSP.st_fail) begin
                        d.sterr = {FMT_RSP.st_code, FMT_RSP.st_num};
                        d.stat[7:0] = ST_FAIL_BYTE;
                        d.stat[B_ERR] = 1'b1;
                        d.st_fail = 1'b1;
                    end
                    d.state = S_END;
                end
            end
            S_END: begin
                d.stat[B_IDLE] = 1'b1;
                d.stat[B_CMP] = !d.stat[B_ERR];
                d.state = S_IDLE;
            end
            default: d.state = S_IDLE;
        endcase

        // termination by power warning while a command runs
        if (PWR_WARN && busy) begin
            d.stat[B_ABN] = 1'b1;
            d.stat[B_ERR] = 1'b1;
            d.mem.req = 1'b0;
            d.loop = 1'b0;
            d.state = S_END;
        end
        if (IORST) begin
            d.stat = STAT_RESET;
            d.stat[B_ABN] = busy;
            d.amask = '0;
            d.mem.req = 1'b0;
            d.push_v = 1'b0;
            d.loop = 1'b0;
            d.ctr = '0;
            d.state = S_TEST;
        end
        // completion interrupt only while idle and enabled
        d.cirq = d.stat[B_IDLE] && d.stat[B_IE] &&
                 (d.stat[B_CMP] || d.stat[B_ERR]);
        d.airq = d.stat[B_IDLE] && |(ATTN & d.amask);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
            q.state <= S_TEST;
            q.stat <= STAT_RESET;
        end else begin
            q <= d;
        end
    end
endmodule : dcs_regs

`default_nettype wire

/* File: hw/dcs_pkg.sv */
// Constants, types and layouts for the disk command/status word bank.
// Assumes a host register port of eight 16-bit words, word 0..7.
package dcs_pkg;
    // -------------------------------------------------------------
    // word indices (host register select)
    // -------------------------------------------------------------
    localparam logic [2:0] IDX_ATTN  = 3'h0;
    localparam logic [2:0] IDX_CMD   = 3'h1;
    localparam logic [2:0] IDX_STERR = 3'h2;
    localparam logic [2:0] IDX_MAINT = 3'h3;
    localparam logic [2:0] IDX_COUNT = 3'h4;
    localparam logic [2:0] IDX_ADLO  = 3'h5;
    localparam logic [2:0] IDX_UNIT  = 3'h6;
    localparam logic [2:0] IDX_STAT  = 3'h7;
    // -------------------------------------------------------------
    // field positions: documented bit n sits at vector bit 15-n
    // -------------------------------------------------------------
    localparam int B_MSB    = 15;
    localparam int B_IDLE   = 15;
    localparam int B_CMP    = 14;
    localparam int B_ERR    = 13;
    localparam int B_IE     = 12;
    localparam int B_ABN    = 8;
    localparam int B_ME     = 7;
    localparam int B_TO     = 5;
    localparam int B_CTO    = 2;
    localparam int B_UE     = 0;
    localparam int B_LOOP   = 15;
    localparam int B_CTRL   = 14;
    localparam int B_OFFL   = 14;
    localparam int B_ADLSB  = 0;
    localparam logic [2:0] CODE_MAINT = 3'h7;
    localparam logic [5:0] MT_LAST_TEST = 6'h3B;
    localparam logic [5:0] MT_WR_PMEM   = 6'h3E;
    localparam logic [7:0] ST_FAIL_BYTE = 8'hFF;
    localparam logic [15:0] STAT_RESET  = 16'h8000;
    localparam logic [15:0] ADDR_STEP   = 16'h0002;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_NS    = 20;
    localparam int BUS_TO_NS = 10000;
    localparam int BUS_TO_CYC = BUS_TO_NS / CLK_NS;
    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [5:0] {
        S_TEST  = 6'h01,
        S_IDLE  = 6'h02,
        S_FCMD  = 6'h04,
        S_DMA   = 6'h08,
        S_FWAIT = 6'h10,
        S_END   = 6'h20
    } state_t;
    typedef struct packed {
        logic [2:0]  sel;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic        req;
        logic [19:0] addr;
    } mem_req_t;
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } mem_rsp_t;
    typedef struct packed {
        logic        valid;
        logic [4:0]  code;
        logic [3:0]  unit;
        logic [15:0] count;
        logic [7:0]  maint;
    } fmt_cmd_t;
    typedef struct packed {
        logic        done;
        logic        bus_err;
        logic        st_fail;
        logic [7:0]  st_code;
        logic [7:0]  st_num;
        logic [15:0] remain;
    } fmt_rsp_t;
    typedef struct packed {
        logic       fail;
        logic [7:0] code;
        logic [7:0] num;
    } st_res_t;
endpackage : dcs_pkg

/* File: testbench/dcs_regs_checker.sv */
// Concurrent checks on the command/status word bank top ports.
// Assumes one clock domain with RST_N as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dcs_regs_checker (
    input wire logic              CLK,
    input wire logic              RST_N,
    input wire logic              IORST,
    input wire dcs_pkg::reg_req_t REG,
    input wire dcs_pkg::mem_req_t MEM_OUT,
    input wire dcs_pkg::mem_rsp_t MEM_IN,
    input wire dcs_pkg::fmt_cmd_t FMT_CMD,
    input wire logic [15:0]       FMT_DATA,
    input wire logic              FMT_DVALID,
    input wire logic              FMT_DREADY,
    input wire logic              CMD_IRQ
);
    import dcs_pkg::*;
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    logic [9:0] wait_q;
    logic       w7;
    assign w7 = REG.wr && REG.sel == IDX_STAT;
    // cycles of the pending request
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_q <= 10'h000;
        end else begin
            wait_q <= MEM_OUT.req ? wait_q + 10'h001 : 10'h000;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    chk_reset_quiet: assert property ($rose(RST_N) |-> !CMD_IRQ
        && !MEM_OUT.req && !FMT_CMD.valid) else $error("active after reset");
    chk_iorst_quiet: assert property (IORST |=> !CMD_IRQ
        && !MEM_OUT.req) else $error("active after io reset");
    chk_ie_off: assert property (w7 && !REG.wdata[B_IE] |=> !CMD_IRQ)
        else $error("interrupt kept with enable cleared");
    chk_flags_clear: assert property (w7 && !REG.wdata[B_CMP]
        && !REG.wdata[B_ERR] |=> !CMD_IRQ) else $error("interrupt kept");
    chk_irq_pending: assert property (w7 && REG.wdata[B_IDLE]
        && REG.wdata[B_IE] && (REG.wdata[B_CMP] || REG.wdata[B_ERR])
        |=> CMD_IRQ) else $error("pending flag gave no interrupt");
    chk_req_drop: assert property (MEM_OUT.req
        && (MEM_IN.ack || MEM_IN.err) |=> !MEM_OUT.req)
        else $error("request held after response");
    chk_addr_even: assert property (MEM_OUT.req |-> !MEM_OUT.addr[0])
        else $error("odd memory address");
    chk_bus_timeout: assert property (wait_q < 10'h1F8)
        else $error("memory cycle not timed out");
    chk_unit_onehot: assert property (FMT_CMD.valid
        |-> $onehot(FMT_CMD.unit)) else $error("command to bad unit");
    chk_fifo_hold: assert property (FMT_DVALID && !FMT_DREADY && !IORST
        |=> FMT_DVALID && $stable(FMT_DATA)) else $error("fifo head lost");
    cov_mem_err: cover property (MEM_OUT.req && MEM_IN.err);
    cov_irq: cover property ($rose(CMD_IRQ));
    cov_stall: cover property (FMT_DVALID && !FMT_DREADY);
endmodule : dcs_regs_checker

bind dcs_regs dcs_regs_checker u_chk (
    .CLK(CLK), .RST_N(RST_N), .IORST(IORST), .REG(REG),
    .MEM_OUT(MEM_OUT), .MEM_IN(MEM_IN), .FMT_CMD(FMT_CMD),
    .FMT_DATA(FMT_DATA), .FMT_DVALID(FMT_DVALID),
    .FMT_DREADY(FMT_DREADY), .CMD_IRQ(CMD_IRQ)
);
`default_nettype wire

/* File: testbench/far_side_model.sv */
// Host memory and formatter stand-in on the DMA side of the bank.
// Assumes the dcs_regs memory and formatter ports on the same clock.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [1:0]        mode,
    input  wire logic              stall,
    input  wire logic              bus_err,
    input  wire dcs_pkg::mem_req_t mem_out,
    output dcs_pkg::mem_rsp_t      mem_in,
    input  wire dcs_pkg::fmt_cmd_t fmt_cmd,
    input  wire logic              fmt_dvalid,
    output dcs_pkg::fmt_rsp_t      fmt_rsp,
    output logic                   fmt_dready,
    output int                     cmds,
    output int                     words
);
    import dcs_pkg::*;
    // -------------------------------------------------------------
    // mode 0 quick, 1 fault at 1002, 2 never answers, 3 slow
    // -------------------------------------------------------------
    int   wait_q;
    int   need;
    logic due;
    logic hit;
    logic bad;
    assign fmt_dready = !stall;
    assign bad = mode == 2'h1 && mem_out.addr[14:0] == 15'h1002;
    assign hit = mem_out.req && !mem_in.ack && !mem_in.err
        && mode != 2'h2 && wait_q == ((mode == 2'h3) ? 40 : 2);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_in <= '0;
            fmt_rsp <= '0;
            wait_q <= 0;
            need <= 0;
            due <= 1'b0;
            cmds <= 0;
            words <= 0;
        end else begin
            // idle data lines flip: no stale word
            mem_in.rdata <= hit ? mem_out.addr[15:0] : ~mem_in.rdata;
            mem_in.ack <= hit && !bad;
            mem_in.err <= hit && bad;
            wait_q <= (mem_out.req && !hit) ? wait_q + 1 : 0;
            fmt_rsp.done <= due && need == 0;
            fmt_rsp.bus_err <= bus_err;
            if (due && need == 0) begin
                due <= 1'b0;
            end
            if (fmt_cmd.valid) begin
                cmds <= cmds + 1;
                due <= 1'b1;
                need <= fmt_cmd.code[0] ? (int'(fmt_cmd.count) + 1) / 2 : 0;
            end else if (fmt_dvalid && !stall) begin
                need <= need - 1;
            end
            if (fmt_dvalid && !stall) begin
                words <= words + 1;
            end
        end
    end
endmodule : far_side_model
`default_nettype wire

/* File: testbench/disk_command_status_registers_tb.sv */
// Self-checking bench for the command/status word bank.
// Assumes dcs_regs, far_side_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module disk_command_status_registers_tb;
    import dcs_pkg::*;
    logic clk, rst_n, iorst, pwr_warn, stall, berr, cmd_irq, attn_irq;
    logic [1:0]  mode;
    logic [3:0]  attn;
    logic [15:0] rdata, fmt_data;
    logic        fmt_dvalid, fmt_dready;
    reg_req_t    host_req;
    mem_req_t    mem_out;
    mem_rsp_t    mem_in;
    fmt_cmd_t    fmt_cmd;
    fmt_rsp_t    fmt_rsp;
    st_res_t     st_res;
    int          bad_count, checks_done, cyc, cmds, words, i, k, n;
    logic [15:0] ev [3] = '{16'hA080, 16'hA020, 16'hA004};
    dcs_regs #(.ST_CYCLES(4), .FIFO_D(16)) dut (
        .CLK(clk), .RST_N(rst_n), .IORST(iorst), .PWR_WARN(pwr_warn),
        .REG(host_req), .REG_RDATA(rdata), .MEM_OUT(mem_out),
        .MEM_IN(mem_in), .FMT_CMD(fmt_cmd), .FMT_RSP(fmt_rsp),
        .FMT_DATA(fmt_data), .FMT_DVALID(fmt_dvalid),
        .FMT_DREADY(fmt_dready), .ST_RES(st_res), .ATTN(attn),
        .CMD_IRQ(cmd_irq), .ATTN_IRQ(attn_irq));
    far_side_model far (
        .clk(clk), .rst_n(rst_n), .mode(mode), .stall(stall),
        .bus_err(berr), .mem_out(mem_out), .mem_in(mem_in),
        .fmt_cmd(fmt_cmd), .fmt_dvalid(fmt_dvalid), .fmt_rsp(fmt_rsp),
        .fmt_dready(fmt_dready), .cmds(cmds), .words(words));
    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task results;
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    task wr(input logic [2:0] s, input logic [15:0] d);
        @(posedge clk);
        host_req <= '{sel: s, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        host_req.wr <= 1'b0;
    endtask : wr
    task rd(input logic [2:0] s, input logic [15:0] m, e, input string nm);
        @(posedge clk);
        host_req <= '{sel: s, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(posedge clk);
        host_req.rd <= 1'b0;
        #1 chk(nm, rdata & m, e);
    endtask : rd
    task irq(input logic e);
        repeat (2) @(posedge clk);
        #1 chk("cmd_irq", {15'h0000, cmd_irq}, {15'h0000, e});
    endtask : irq
    // address low fixed at 1000; start with interrupt enabled
    task go(input logic [15:0] c1, c3, c4, c6);
        wr(IDX_CMD, c1);
        wr(IDX_MAINT, c3);
        wr(IDX_COUNT, c4);
        wr(IDX_ADLO, 16'h1000);
        wr(IDX_UNIT, c6);
        wr(IDX_STAT, 16'h1000);
    endtask : go
    task wt;
        for (k = 0; k < 3000 && (k == 0 || cmd_irq !== 1'b1); k++)
            @(posedge clk);
        chk("irq_wait", {15'h0000, cmd_irq}, 16'h0001);
    endtask : wt
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    // -------------------------------------------------------------
    // sequence
    // -------------------------------------------------------------
    initial begin
        clk = 1'b0; rst_n = 1'b0; iorst = 1'b0; pwr_warn = 1'b0;
        stall = 1'b0; berr = 1'b0; mode = 2'h0; attn = 4'h0;
        host_req = '0; st_res = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        rd(IDX_STAT, 16'hFFFF, STAT_RESET, "stat_reset");
        attn <= 4'h1;
        wr(IDX_ATTN, 16'h0001);
        repeat (2) @(posedge clk);
        chk("attn_irq", {15'h0000, attn_irq}, 16'h0001);
        wr(IDX_ATTN, 16'h0000);
        // slow memory and stalled formatter: fifo fills, dma must wait
        mode <= 2'h3;
        stall <= 1'b1;
        go(16'h8300, 16'h0000, 16'h0028, 16'h0801);
        rd(IDX_CMD, 16'hFFFF, 16'h0300, "busy_msb");
        repeat (1200) @(posedge clk);
        chk("full_req", {15'h0000, mem_out.req}, 16'h0000);
        stall <= 1'b0;
        wt();
        rd(IDX_STAT, 16'hFFFF, 16'hD000, "done_stat");
        rd(IDX_ADLO, 16'hFFFF, 16'h1028, "end_addr");
        rd(IDX_UNIT, 16'hFFFF, 16'h0801, "addr_high");
        rd(IDX_COUNT, 16'hFFFF, 16'h0000, "remain");
        chk("words", 16'(words), 16'h0014);
        wr(IDX_STAT, 16'h9000);
        irq(1'b0);
        wr(IDX_STAT, 16'hC000);
        irq(1'b0);
        wr(IDX_STAT, 16'hD000);
        irq(1'b1);
        wr(IDX_STAT, 16'hC000);
        irq(1'b0);
        mode <= 2'h0;
        for (i = 0; i < 2; i++) begin
            n = cmds;
            go(16'h0300, 16'h0000, 16'h0004, i ? 16'h0C00 : 16'h0000);
            wt();
            rd(IDX_STAT, 16'hF001, 16'hB001, "unit_err");
            rd(IDX_ATTN, 16'h4000, 16'h4000, "offline");
            chk("unit_cmds", 16'(cmds), 16'(n));
            wr(IDX_STAT, 16'h9000);
            irq(1'b0);
        end
        for (i = 0; i < 3; i++) begin
            mode <= (i == 0) ? 2'h1 : ((i == 1) ? 2'h2 : 2'h0);
            berr <= (i == 2);
            n = words;
            go(16'h0300, 16'h0000, 16'h0006, 16'h0801);
            wt();
            rd(IDX_STAT, 16'hE0A4, ev[i], "err_stat");
            chk("pad_words", 16'(words - n), 16'h0003);
            if (i == 0) begin
                rd(IDX_ADLO, 16'hFFFF, 16'h1004, "err_addr");
            end
        end
        mode <= 2'h0;
        berr <= 1'b0;
        for (i = 0; i < 2; i++) begin
            n = cmds;
            go(i ? 16'h0700 : 16'h8700, 16'h7E00, 16'h0004, 16'h0801);
            wt();
            chk("maint_route", 16'(cmds - n), 16'(i));
        end
        go(16'h8700, 16'hC000, 16'h0000, 16'h0801);
        repeat (100) @(posedge clk);
        rd(IDX_STAT, 16'h8000, 16'h0000, "loop_busy");
        iorst <= 1'b1;
        @(posedge clk);
        iorst <= 1'b0;
        repeat (20) @(posedge clk);
        rd(IDX_STAT, 16'hFFFF, 16'h8100, "io_reset");
        mode <= 2'h3;
        go(16'h0300, 16'h0000, 16'h0006, 16'h0801);
        repeat (50) @(posedge clk);
        pwr_warn <= 1'b1;
        @(posedge clk);
        pwr_warn <= 1'b0;
        wt();
        rd(IDX_STAT, 16'hE100, 16'hA100, "pwr_warn");
        // second power reset with a failing self-test
        rst_n <= 1'b0;
        mode <= 2'h0;
        st_res <= '{fail: 1'b1, code: 8'h5A, num: 8'h03};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        rd(IDX_STERR, 16'hFFFF, 16'h5A03, "st_word");
        rd(IDX_STAT, 16'h00FF, 16'h00FF, "st_fail");
        n = cmds;
        go(16'h0300, 16'h0000, 16'h0002, 16'h0801);
        wt();
        rd(IDX_STAT, 16'h00FF, 16'h00FF, "st_hold");
        chk("st_inhibit", 16'(cmds), 16'(n));
        results();
    end
endmodule : disk_command_status_registers_tb
`default_nettype wire
